// *** verilog/pact_pkg.sv ***
// Purpose: Constants and carriers for the protocol-aware countdown timer
// Assumes: Byte-wide registers on word-aligned Avalon-MM addresses
// Notes: Contract
// Contract
// - Auto-start set: timer starts at end of every transmission.
// - Auto-start set: timer starts when field appears and initial-field option set.
// - Auto-start with single receive: stop right after first received data bit.
// - Auto-start with multi receive: no stop on reception, only stop command.
// - Auto-start clear: protocol events neither start nor stop the timer.
// - Gate field: 00 none, 01 secure-link pin, 10 aux pin, 11 reserved.
// - Gated mode: running flag shows register enable, does not affect gating.
// - Reload-on-zero set: at zero reload value and keep counting.
// - Reload-on-zero clear: stop at zero and set expiry interrupt flag.
// - Prescaler is lower nibble of mode register with separate lower byte.
// - Tick rate is the base clock divided by the prescaler value.
// - Every start loads the counter with the 16-bit reload value.
// - Reload byte writes affect only the next start or reload at zero.
// - Lower prescaler byte lives in its own read-write register.
package pact_pkg;
    // Register indices as printed; byte address is index times four
    localparam logic [15:0] IDX_TMODE = 16'h631a;
    localparam logic [15:0] IDX_TPRESC = 16'h631b;
    localparam logic [15:0] IDX_RELOAD_HI = 16'h631c;
    localparam logic [15:0] IDX_RELOAD_LO = 16'h631d;
    localparam logic [15:0] IDX_COUNT_HI = 16'h631e;
    localparam logic [15:0] IDX_COUNT_LO = 16'h631f;
    localparam logic [15:0] IDX_CONTROL = 16'h6330;
    localparam logic [15:0] IDX_STATUS = 16'h6331;
    localparam logic [15:0] IDX_IRQ_CLEAR = 16'h6332;
    localparam logic [15:0] IDX_IRQ_ENABLE = 16'h6333;
    localparam logic [15:0] IDX_OPTIONS = 16'h6334;

    localparam int ADDR_W = 18;

    // Mode register fields
    localparam int TM_AUTO = 7;
    localparam int TM_GATE_HI = 6;
    localparam int TM_GATE_LO = 5;
    localparam int TM_RESTART = 4;
    localparam logic [7:0] TMODE_RST = 8'h00;
    localparam logic [7:0] BYTE_RST = 8'h00;

    // Control command bits (write-one pulses)
    localparam int CTL_START = 0;
    localparam int CTL_STOP = 1;
    // Options register bits
    localparam int OPT_INIT_FIELD = 0;
    localparam int OPT_MULTI_RX = 1;
    // Status and interrupt bits
    localparam int ST_RUNNING = 0;
    localparam int IRQ_EXPIRED = 0;
    localparam int IRQ_STARTED = 1;
    localparam int IRQ_STOPPED = 2;
    localparam int IRQ_W = 3;

    // Timing
    localparam int SYS_CLK_HZ = 25_000_000;
    localparam int BASE_CLK_HZ = 6_780_000;
    localparam int PHASE_W = 26;

    typedef enum logic [1:0]
    {
        GATE_NONE = 2'b00,
        GATE_SECURE_LINK_INPUT_PIN = 2'b01,
        GATE_AUX = 2'b10,
        GATE_RSVD = 2'b11
    } pact_gate_e;

    typedef struct packed
    {
        logic tx_end;
        logic field_on;
        logic rx_first_bit;
    } pact_events_s;
endpackage

// *** verilog/pact_tick_gen.sv ***
// Purpose: Base-clock enable and prescaled timer tick
// Assumes: System clock faster than the base clock
// Notes: Base clock is a fractional accumulator enable
`timescale 1ns/1ps
module pact_tick_gen #(
    parameter int SYS_HZ = pact_pkg::SYS_CLK_HZ,
    parameter int BASE_HZ = pact_pkg::BASE_CLK_HZ
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic run,
    input wire logic restart,
    input wire logic [11:0] prescale,
    // Tick
    output logic tick
);
    // Accumulator must also hold the system rate
    if (BASE_HZ <= 0 || BASE_HZ >= SYS_HZ || SYS_HZ >= 2 ** pact_pkg::PHASE_W)
    begin
        $error("Base clock must be slower than system clock");
    end

    logic [pact_pkg::PHASE_W-1:0] phase_r;
    logic [pact_pkg::PHASE_W:0] phase_sum;
    logic base_en;
    logic [11:0] div_r;
    logic [11:0] limit;

    assign phase_sum = {1'b0, phase_r} + pact_pkg::PHASE_W'(BASE_HZ);
    assign base_en = phase_sum >= (pact_pkg::PHASE_W + 1)'(SYS_HZ);
    // Prescaler zero treated as one
    assign limit = (prescale == 12'h000) ? 12'h001 : prescale;

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            phase_r <= '0;
        else if (base_en)
            phase_r <= pact_pkg::PHASE_W'(phase_sum - (pact_pkg::PHASE_W + 1)'(SYS_HZ));
        else
            phase_r <= pact_pkg::PHASE_W'(phase_sum);
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n || restart || !run)
            div_r <= 12'h000;
        else if (base_en)
            div_r <= (div_r + 12'h001 >= limit) ? 12'h000 : div_r + 12'h001;
    end

    assign tick = run && base_en && (div_r + 12'h001 >= limit);
endmodule

// *** verilog/pact_timer.sv ***
// Purpose: Protocol-aware countdown timer with Avalon-MM registers
// Assumes: Protocol event inputs are one-cycle pulses synchronous to clk_sys
// Notes: Registers are byte wide in the low bits of each word
`timescale 1ns/1ps
module pact_timer
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Avalon-MM slave
    input wire logic [pact_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [1:0] avs_response,
    // Protocol events
    input wire pact_pkg::pact_events_s proto_ev,
    // Gate pins
    input wire logic secure_link_input_pin,
    input wire logic auxiliary_pin_one,
    // Status
    output logic count_active_flag,
    output logic count_expired_irq,
    output logic irq
);
    localparam int IRQ_W_L = pact_pkg::IRQ_W;

    logic [7:0] tmode_r;
    logic [7:0] presc_lo_r;
    logic [7:0] reload_hi_r;
    logic [7:0] reload_lo_r;
    logic [1:0] options_r;
    logic [IRQ_W_L-1:0] irq_stat_r;
    logic [IRQ_W_L-1:0] irq_en_r;
    logic [15:0] count_r;
    logic running_r;
    logic ack_r;
    logic [31:0] rdata_r;
    logic [1:0] resp_r;

    logic [15:0] idx;
    logic wr_ok;
    logic byte0;
    logic protocol_auto;
    logic [1:0] gate_source_select;
    logic reload_on_zero;
    logic [11:0] prescale;
    logic [15:0] countdown_reload_value;
    logic sw_start;
    logic stop_count_command;
    logic auto_start;
    logic auto_stop;
    logic start_ev;
    logic stop_ev;
    logic gate_open;
    logic tick;
    logic at_zero;
    logic expire_ev;
    logic mapped;
    logic new_req;
    logic [7:0] rd_mux;
    logic [IRQ_W_L-1:0] irq_set;
    logic wr_mode;
    logic wr_presc;
    logic wr_rhi;
    logic wr_rlo;
    logic wr_ctl;
    logic wr_clear;
    logic wr_en;
    logic wr_opt;

    assign idx = 16'(avs_address >> 2);
    assign byte0 = avs_byteenable[0];
    assign new_req = (avs_read || avs_write) && !ack_r;
    // Writes act in the first cycle of a request only
    assign wr_ok = avs_write && !ack_r && byte0;

    // Write selects
    assign wr_mode = wr_ok && idx == pact_pkg::IDX_TMODE;
    assign wr_presc = wr_ok && idx == pact_pkg::IDX_TPRESC;
    assign wr_rhi = wr_ok && idx == pact_pkg::IDX_RELOAD_HI;
    assign wr_rlo = wr_ok && idx == pact_pkg::IDX_RELOAD_LO;
    assign wr_ctl = wr_ok && idx == pact_pkg::IDX_CONTROL;
    assign wr_clear = wr_ok && idx == pact_pkg::IDX_IRQ_CLEAR;
    assign wr_en = wr_ok && idx == pact_pkg::IDX_IRQ_ENABLE;
    assign wr_opt = wr_ok && idx == pact_pkg::IDX_OPTIONS;

    assign protocol_auto = tmode_r[pact_pkg::TM_AUTO];
    assign gate_source_select = tmode_r[pact_pkg::TM_GATE_HI:pact_pkg::TM_GATE_LO];
    assign reload_on_zero = tmode_r[pact_pkg::TM_RESTART];
    assign prescale = {tmode_r[3:0], presc_lo_r};
    assign countdown_reload_value = {reload_hi_r, reload_lo_r};

    assign sw_start = wr_ctl && avs_writedata[pact_pkg::CTL_START];
    assign stop_count_command = wr_ctl && avs_writedata[pact_pkg::CTL_STOP];

    // Protocol events only matter with auto-start
    assign auto_start = protocol_auto && (proto_ev.tx_end
        || (options_r[pact_pkg::OPT_INIT_FIELD] && proto_ev.field_on));
    assign auto_stop = protocol_auto && running_r && proto_ev.rx_first_bit
        && !options_r[pact_pkg::OPT_MULTI_RX];

    // Stop command outranks any start in the same cycle
    assign stop_ev = stop_count_command || auto_stop;
    assign start_ev = (sw_start || auto_start) && !stop_count_command;

    always_comb
    begin
        case (pact_pkg::pact_gate_e'(gate_source_select))
            pact_pkg::GATE_NONE: gate_open = 1'b1;
            pact_pkg::GATE_SECURE_LINK_INPUT_PIN: gate_open = secure_link_input_pin;
            pact_pkg::GATE_AUX: gate_open = auxiliary_pin_one;
            pact_pkg::GATE_RSVD: gate_open = 1'b0;
            default: gate_open = 1'b0;
        endcase
    end

    // Prescaler phase restarts at every start
    pact_tick_gen u_tick
    (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .run(running_r && gate_open && !start_ev),
        .restart(start_ev),
        .prescale(prescale),
        .tick(tick)
    );

    // Expiry on the tick that leaves one, or on a tick at zero
    assign at_zero = count_r == 16'h0000;
    assign expire_ev = running_r && tick && (at_zero || count_r == 16'h0001)
        && !stop_ev && !start_ev;

    // Counter
    // A start outranks a tick in the same cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            count_r <= 16'h0000;
        else if (start_ev)
            count_r <= countdown_reload_value;
        else if (running_r && tick && !stop_ev)
        begin
            if (at_zero && reload_on_zero)
                count_r <= countdown_reload_value;
            else if (!at_zero)
                count_r <= count_r - 16'h0001;
        end
    end

    // Running state; reports enable regardless of gate
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            running_r <= 1'b0;
        else if (stop_ev)
            running_r <= 1'b0;
        else if (start_ev)
            running_r <= 1'b1;
        else if (expire_ev && !reload_on_zero)
            running_r <= 1'b0;
    end

    assign count_active_flag = running_r;

    // Events that set status bits
    always_comb
    begin
        irq_set = '0;
        irq_set[pact_pkg::IRQ_EXPIRED] = expire_ev;
        irq_set[pact_pkg::IRQ_STARTED] = start_ev;
        irq_set[pact_pkg::IRQ_STOPPED] = stop_ev && running_r;
    end

    // Sticky interrupt status; set wins over clear
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            irq_stat_r <= '0;
        else
        begin
            for (int i = 0; i < IRQ_W_L; i++)
            begin
                if (irq_set[i])
                    irq_stat_r[i] <= 1'b1;
                else if (wr_clear && avs_writedata[i])
                    irq_stat_r[i] <= 1'b0;
            end
        end
    end

    assign count_expired_irq = irq_stat_r[pact_pkg::IRQ_EXPIRED];
    // Level output while an enabled bit is set
    assign irq = |(irq_stat_r & irq_en_r);

    // Writable registers, one block each
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            tmode_r <= pact_pkg::TMODE_RST;
        else if (wr_mode)
            tmode_r <= avs_writedata[7:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            presc_lo_r <= pact_pkg::BYTE_RST;
        else if (wr_presc)
            presc_lo_r <= avs_writedata[7:0];
    end

    // Reload bytes reach the counter only at a start or a reload-on-zero at zero
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            reload_hi_r <= pact_pkg::BYTE_RST;
        else if (wr_rhi)
            reload_hi_r <= avs_writedata[7:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            reload_lo_r <= pact_pkg::BYTE_RST;
        else if (wr_rlo)
            reload_lo_r <= avs_writedata[7:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            options_r <= 2'b00;
        else if (wr_opt)
            options_r <= avs_writedata[1:0];
    end

    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            irq_en_r <= '0;
        else if (wr_en)
            irq_en_r <= avs_writedata[IRQ_W_L-1:0];
    end

    always_comb
    begin
        case (idx)
            pact_pkg::IDX_TMODE, pact_pkg::IDX_TPRESC, pact_pkg::IDX_RELOAD_HI,
            pact_pkg::IDX_RELOAD_LO, pact_pkg::IDX_COUNT_HI, pact_pkg::IDX_COUNT_LO,
            pact_pkg::IDX_CONTROL, pact_pkg::IDX_STATUS, pact_pkg::IDX_IRQ_CLEAR,
            pact_pkg::IDX_IRQ_ENABLE, pact_pkg::IDX_OPTIONS: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // One wait cycle on every request
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            ack_r <= 1'b0;
        else
            ack_r <= new_req;
    end

    // Response stands until the next request is answered
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            resp_r <= 2'b00;
        else if (new_req)
            resp_r <= mapped ? 2'b00 : 2'b11;
    end

    // Count bytes are read live, not latched as a pair
    always_comb
    begin
        case (idx)
            pact_pkg::IDX_TMODE: rd_mux = tmode_r;
            pact_pkg::IDX_TPRESC: rd_mux = presc_lo_r;
            pact_pkg::IDX_RELOAD_HI: rd_mux = reload_hi_r;
            pact_pkg::IDX_RELOAD_LO: rd_mux = reload_lo_r;
            pact_pkg::IDX_COUNT_HI: rd_mux = count_r[15:8];
            pact_pkg::IDX_COUNT_LO: rd_mux = count_r[7:0];
            pact_pkg::IDX_STATUS: rd_mux = 8'(irq_stat_r);
            pact_pkg::IDX_IRQ_ENABLE: rd_mux = 8'(irq_en_r);
            pact_pkg::IDX_OPTIONS: rd_mux = {6'h00, options_r};
            pact_pkg::IDX_CONTROL: rd_mux = {7'h00, running_r};
            default: rd_mux = 8'h00;
        endcase
    end

    // Read data registered in the wait cycle
    always_ff @(posedge clk_sys)
    begin
        if (!rst_n)
            rdata_r <= 32'h0000_0000;
        else if (avs_read && !ack_r)
            rdata_r <= {24'h00_0000, rd_mux};
    end

    assign avs_waitrequest = (avs_read || avs_write) && !ack_r;
    assign avs_readdata = rdata_r;
    assign avs_response = resp_r;
endmodule

// *** testbench/pact_timer_assertions.sv ***
// Purpose: Port-level assertions for the countdown timer
// Assumes: One wait state on every register access
// Notes: Bound to pact_timer below
`timescale 1ns/1ps
module pact_timer_assertions
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bus
    input wire logic [pact_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic [1:0] avs_response,
    // Events and status
    input wire pact_pkg::pact_events_s proto_ev,
    input wire logic count_active_flag,
    input wire logic count_expired_irq
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    logic [15:0] idx;
    logic mapped;
    logic go_ev;
    logic halt_ev;
    assign idx = avs_address[17:2];
    assign mapped = (idx >= pact_pkg::IDX_TMODE && idx <= pact_pkg::IDX_COUNT_LO)
        || (idx >= pact_pkg::IDX_CONTROL && idx <= pact_pkg::IDX_OPTIONS);
    assign go_ev = proto_ev.tx_end || proto_ev.field_on || avs_write;
    assign halt_ev = proto_ev.rx_first_bit || avs_write;
    sequence req_wait;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence rd_done;
        avs_read && !avs_waitrequest;
    endsequence
    bus_wait_a: assert property (req_wait |=> !avs_waitrequest)
        else $error("wait state longer than one cycle");
    bus_idle_a: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest without request");
    rd_width_a: assert property (rd_done |-> avs_readdata[31:8] == 24'h00_0000)
        else $error("read data above low byte");
    rd_resp_a: assert property (rd_done |-> avs_response == (mapped ? 2'b00 : 2'b11))
        else $error("wrong response code");
    expiry_sticky_a: assert property (count_expired_irq && !avs_write |=> count_expired_irq)
        else $error("expiry flag dropped without clear");
    start_cause_a: assert property ($rose(count_active_flag) |-> $past(go_ev) || $past(go_ev, 2))
        else $error("timer started without cause");
    stop_cause_a: assert property ($fell(count_active_flag) |->
        $past(halt_ev) || $past(halt_ev, 2) || count_expired_irq)
        else $error("timer stopped without cause");
    expiry_run_a: assert property ($rose(count_expired_irq) |-> $past(count_active_flag))
        else $error("expiry while idle");
endmodule

bind pact_timer pact_timer_assertions chk
(
    .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_response(avs_response), .proto_ev(proto_ev), .count_active_flag(count_active_flag),
    .count_expired_irq(count_expired_irq)
);

// *** testbench/pact_timer_test.sv ***
// Purpose: Self-checking bench for the countdown timer
// Assumes: One wait state, registers on word addresses
// Notes: Gate 11 blocks counting
`timescale 1ns/1ps
module pact_timer_test;
    localparam logic [15:0] A_MODE = pact_pkg::IDX_TMODE;
    localparam logic [15:0] A_PRE = pact_pkg::IDX_TPRESC;
    localparam logic [15:0] A_RHI = pact_pkg::IDX_RELOAD_HI;
    localparam logic [15:0] A_RLO = pact_pkg::IDX_RELOAD_LO;
    localparam logic [15:0] A_CHI = pact_pkg::IDX_COUNT_HI;
    localparam logic [15:0] A_CLO = pact_pkg::IDX_COUNT_LO;
    localparam logic [15:0] A_CTL = pact_pkg::IDX_CONTROL;
    localparam logic [15:0] A_OPT = pact_pkg::IDX_OPTIONS;
    logic clk_sys;
    logic rst_n;
    logic [17:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [1:0] avs_response;
    pact_pkg::pact_events_s proto_ev;
    logic sl_pin;
    logic aux_pin;
    logic active;
    logic expired;
    logic irq;
    logic [7:0] rd;
    int num_errors;
    int num_checks;
    pact_timer uut
    (
        .clk_sys(clk_sys), .rst_n(rst_n), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .avs_response(avs_response), .proto_ev(proto_ev), .secure_link_input_pin(sl_pin),
        .auxiliary_pin_one(aux_pin), .count_active_flag(active),
        .count_expired_irq(expired), .irq(irq)
    );
    task automatic test_done();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        avs_address <= {idx, 2'b00};
        avs_writedata <= {24'h00_0000, d};
        avs_read <= !wr;
        avs_write <= wr;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0)
        begin
            n++;
            if (n > 50)
            begin
                num_errors++;
                test_done();
            end
            @(posedge clk_sys);
        end
        rd = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic rdchk(input logic [15:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        check({24'h00_0000, rd}, {24'h00_0000, exp});
    endtask
    task automatic pulse(input logic [2:0] ev);
        proto_ev <= pact_pkg::pact_events_s'(ev);
        @(posedge clk_sys);
        proto_ev <= pact_pkg::pact_events_s'(3'b000);
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic t_regs();
        rdchk(A_MODE, 8'h00);
        rdchk(A_PRE, 8'h00);
        rdchk(16'h6300, 8'h00);
        check(avs_response, 2'b11);
        bus(1'b1, A_MODE, 8'h5a);
        bus(1'b1, A_PRE, 8'ha5);
        rdchk(A_MODE, 8'h5a);
        rdchk(A_PRE, 8'ha5);
        $display("test regs done");
    endtask
    task automatic t_expire();
        int n;
        bus(1'b1, A_MODE, 8'h00);
        bus(1'b1, A_PRE, 8'h01);
        bus(1'b1, A_RHI, 8'h00);
        bus(1'b1, A_RLO, 8'h05);
        bus(1'b1, pact_pkg::IDX_IRQ_ENABLE, 8'h01);
        bus(1'b1, A_CTL, 8'h01);
        check(active, 1'b1);
        n = 0;
        while (expired !== 1'b1)
        begin
            n++;
            if (n > 500)
            begin
                num_errors++;
                test_done();
            end
            @(posedge clk_sys);
        end
        repeat (2) @(posedge clk_sys);
        check(expired, 1'b1);
        check(active, 1'b0);
        rdchk(A_CLO, 8'h00);
        rdchk(pact_pkg::IDX_STATUS, 8'h03);
        check(irq, 1'b1);
        bus(1'b1, pact_pkg::IDX_IRQ_ENABLE, 8'h00);
        check(irq, 1'b0);
        bus(1'b1, pact_pkg::IDX_IRQ_CLEAR, 8'h07);
        check(expired, 1'b0);
        rdchk(pact_pkg::IDX_STATUS, 8'h00);
        bus(1'b1, A_MODE, 8'h10);
        bus(1'b1, A_CTL, 8'h01);
        repeat (100) @(posedge clk_sys);
        check(active, 1'b1);
        rdchk(A_CHI, 8'h00);
        bus(1'b1, A_CTL, 8'h02);
        $display("test expiry done");
    endtask
    task automatic t_reload();
        bus(1'b1, A_MODE, 8'h0f);
        bus(1'b1, A_PRE, 8'hff);
        bus(1'b1, A_RHI, 8'h01);
        bus(1'b1, A_RLO, 8'h00);
        bus(1'b1, A_CTL, 8'h01);
        rdchk(A_CHI, 8'h01);
        rdchk(A_CLO, 8'h00);
        bus(1'b1, A_RHI, 8'h02);
        rdchk(A_CHI, 8'h01);
        bus(1'b1, A_CTL, 8'h02);
        check(active, 1'b0);
        bus(1'b1, A_CTL, 8'h01);
        rdchk(A_CHI, 8'h02);
        bus(1'b1, A_CTL, 8'h02);
        $display("test reload done");
    endtask
    task automatic t_proto();
        pulse(3'b100);
        check(active, 1'b0);
        bus(1'b1, A_CTL, 8'h01);
        pulse(3'b001);
        check(active, 1'b1);
        bus(1'b1, A_CTL, 8'h02);
        bus(1'b1, A_MODE, 8'h8f);
        pulse(3'b100);
        check(active, 1'b1);
        pulse(3'b001);
        check(active, 1'b0);
        bus(1'b1, A_OPT, 8'h02);
        pulse(3'b100);
        pulse(3'b001);
        check(active, 1'b1);
        bus(1'b1, A_CTL, 8'h02);
        check(active, 1'b0);
        pulse(3'b010);
        check(active, 1'b0);
        bus(1'b1, A_OPT, 8'h01);
        pulse(3'b010);
        check(active, 1'b1);
        bus(1'b1, A_CTL, 8'h02);
        $display("test protocol done");
    endtask
    task automatic t_gate();
        bus(1'b1, A_PRE, 8'h01);
        bus(1'b1, A_RLO, 8'h40);
        for (int g = 1; g < 4; g++)
        begin
            bus(1'b1, A_MODE, {1'b0, 2'(g), 5'h00});
            sl_pin <= (g == 2);
            aux_pin <= (g == 1);
            bus(1'b1, A_CTL, 8'h01);
            repeat (40) @(posedge clk_sys);
            check(active, 1'b1);
            rdchk(A_CTL, 8'h01);
            rdchk(A_CLO, 8'h40);
            sl_pin <= 1'b1;
            aux_pin <= 1'b1;
            repeat (40) @(posedge clk_sys);
            bus(1'b0, A_CLO, 8'h00);
            check(rd != 8'h40, g != 3);
            bus(1'b1, A_CTL, 8'h02);
        end
        $display("test gate done");
    endtask
    task automatic t_rate();
        int exp;
        exp = 255 - 1000 * longint'(pact_pkg::BASE_CLK_HZ) / pact_pkg::SYS_CLK_HZ / 4;
        bus(1'b1, A_MODE, 8'h00);
        bus(1'b1, A_PRE, 8'h04);
        bus(1'b1, A_RLO, 8'hff);
        bus(1'b1, A_CTL, 8'h01);
        repeat (1000) @(posedge clk_sys);
        bus(1'b1, A_CTL, 8'h02);
        bus(1'b0, A_CLO, 8'h00);
        check(int'(rd) >= exp - 2 && int'(rd) <= exp + 2, 1'b1);
        $display("test rate done");
    endtask
    initial
    begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial
    begin
        rst_n = 1'b0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        proto_ev = '0;
        sl_pin = 1'b0;
        aux_pin = 1'b0;
        repeat (16) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        t_expire();
        t_reload();
        t_proto();
        t_gate();
        t_rate();
        test_done();
    end
endmodule
